// [hdl/dsp_shifter_pkg.sv]
// constants, codes and carrier types for the barrel shifter unit
package dsp_shifter_pkg;

    localparam int DATA_W = 16;
    localparam int CODE_W = 8;
    localparam int BEXP_W = 5;
    localparam int RES_W = 32;
    localparam int BANKS = 2;

    // register selects on the data memory bus
    localparam logic [2:0] SEL_INPUT = 3'h0;
    localparam logic [2:0] SEL_SHIFT_EXP = 3'h1;
    localparam logic [2:0] SEL_BLOCK_EXP = 3'h2;
    localparam logic [2:0] SEL_RESULT_LOW = 3'h3;
    localparam logic [2:0] SEL_RESULT_HIGH = 3'h4;

    // bank select bit in the mode status register
    localparam int MODE_BANK_BIT = 0;

    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_SHIFT_EXP = 8'h00;
    localparam logic [4:0] RST_BLOCK_EXP = 5'h00;
    localparam logic RST_BANK = 1'b0;

    // placement arithmetic (9-bit signed)
    localparam logic [8:0] UPPER_OFFSET = 9'h010;
    localparam logic [8:0] FIELD_SPAN = 9'h020;
    localparam logic [8:0] SAT_UP = 9'h020;
    localparam logic [8:0] SAT_DOWN = 9'h1F0;

    // exponent detector constants (8-bit signed)
    localparam logic [7:0] DET_PLUS_ONE = 8'h01;
    localparam logic [7:0] DET_LOWER_BASE = 8'hF1;
    localparam logic [7:0] DET_LOWER_GATE = 8'hF1;

    typedef enum logic [1:0] {
        CTRL_EXPONENT = 2'h0,
        CTRL_NEG_EXPONENT = 2'h1,
        CTRL_IMMEDIATE = 2'h2
    } ctrl_src_t;

    typedef enum logic [1:0] {
        EXT_MSB = 2'h0,
        EXT_CARRY = 2'h1,
        EXT_ZERO = 2'h2
    } ext_src_t;

    typedef enum logic [1:0] {
        DET_UPPER = 2'h0,
        DET_OVERFLOW_UPPER = 2'h1,
        DET_LOWER = 2'h2
    } det_mode_t;

    typedef enum logic [1:0] {
        OPK_SHIFT = 2'h0,
        OPK_MANTISSA_ALIGN = 2'h1,
        OPK_LEADING_SIGN_COUNT = 2'h2,
        OPK_BLOCK_EXP_ADJUST = 2'h3
    } op_kind_t;

    typedef struct packed {
        logic valid;
        op_kind_t kind;
        ctrl_src_t ctrlSrc;
        logic [7:0] immCode;
        logic upperHalfRef;
        ext_src_t extSrc;
        logic orMerge;
        det_mode_t detMode;
        logic useResultBus;
    } shift_op_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [2:0] sel;
        logic [15:0] wrData;
    } dm_access_t;

endpackage

// [hdl/dsp_barrel_shifter.sv]
// barrel shifter unit: array, or/pass, exponent detector, compare, banks
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// - places a 16-bit operand at any of 49 spots in 32 bits, one cycle.
// - 8-bit signed code; positive shifts left, negative shifts right.
// - code comes from shift exponent, its negation, or an immediate.
// - upper or lower half reference, chosen for every operation.
// - zeros fill right of the operand, extension bit fills left.
// - extension bit is operand msb, alu carry flag, or zero.
// - or-merge ors array output into the result, else plain store.
// - 16-bit input register on memory bus; result bus can feed the array.
// - 32-bit result as two 16-bit halves, loadable and readable separately.
// - shift exponent is 8-bit signed via low 8 memory bus bits.
// - block exponent is 5-bit signed via low 5 memory bus bits.
// - both exponents read back sign-extended to 16 bits.
// - reads see the value before a same-cycle write; new value next cycle.
// - two banks of all five registers; mode bit 0 picks the alternate.
// - primary bank after reset; enable/disable pulses also switch banks.
// - upper mode outputs minus the redundant sign count, 0 to -15.
// - overflow-aware upper mode outputs +1 when overflow flag set.
// - upper modes load sign flag: operand msb, inverted on overflow in overflow-aware mode.
// - lower mode uses stored sign flag; updates exponent only if -15.
// - lower mode exponent is offset by -16.
// - block exponent replaced only by a strictly greater exponent.
// - out-of-field codes saturate to all zeros or all extension bits.
// - mantissa align always uses the negated shift exponent.
// - immediate shifts neither read nor change the shift exponent.
module dsp_barrel_shifter
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire dsp_shifter_pkg::dm_access_t dmAccess,
    input wire logic resultBusRdEn,
    input wire logic resultBusRdHigh,
    input wire logic [15:0] resultBusIn,
    input wire dsp_shifter_pkg::shift_op_t shiftOp,
    input wire logic aluCarryFlag,
    input wire logic aluOverflowFlag,
    input wire logic modeStatusWrEn,
    input wire logic [15:0] modeStatusWrData,
    input wire logic bankEnable,
    input wire logic bankDisable,
    output logic [15:0] dmRdData,
    output logic [15:0] resultBusOut,
    output logic activeBank,
    output logic shifterSignFlag
);
    import dsp_shifter_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // banked register storage

    logic [15:0] shifterInput [BANKS];
    logic [7:0] shiftExponent [BANKS];
    logic [4:0] blockExponent [BANKS];
    logic [15:0] resultLow [BANKS];
    logic [15:0] resultHigh [BANKS];

    // counts leading bits equal to the given sign, msb first
    function automatic logic [4:0] leadCount
    (
        input logic [15:0] v,
        input logic s
    );
        logic done;
        logic [4:0] n;
        n = 5'h00;
        done = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            if (!done)
            begin
                if (v[i] == s)
                    n = n + 5'h01;
                else
                    done = 1'b1;
            end
        end
        return n;
    endfunction

    // true when the memory bus names this register with the given strobe
    function automatic logic selHit
    (
        input logic strobe,
        input logic [2:0] sel,
        input logic [2:0] want
    );
        return strobe && (sel == want);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // visible bank views

    logic bank;
    logic [15:0] curInput;
    logic [7:0] curExp;
    logic [4:0] curBlock;
    logic [31:0] curResult;

    assign bank = activeBank;
    assign curInput = shifterInput[bank];
    assign curExp = shiftExponent[bank];
    assign curBlock = blockExponent[bank];
    assign curResult = {resultHigh[bank], resultLow[bank]};

    //////////////////////////////////////////////////////////////////////////
    // operand and control code

    logic [15:0] operand;
    logic [7:0] ctrlCode;
    logic extBit;

    // the result bus carries alu, mac or shifter results from outside
    assign operand = shiftOp.useResultBus ? resultBusIn : curInput;

    always_comb
    begin
        ctrlCode = curExp;
        if (shiftOp.kind == OPK_MANTISSA_ALIGN)
            ctrlCode = 8'h00 - curExp;
        else if (shiftOp.ctrlSrc == CTRL_NEG_EXPONENT)
            ctrlCode = 8'h00 - curExp;
        else if (shiftOp.ctrlSrc == CTRL_IMMEDIATE)
            ctrlCode = shiftOp.immCode;
    end

    always_comb
    begin
        case (shiftOp.extSrc)
            EXT_MSB: extBit = operand[15];
            EXT_CARRY: extBit = aluCarryFlag;
            default: extBit = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // shifter array

    logic [8:0] placeAmount;
    logic [8:0] rightDist;
    logic [79:0] spread;
    logic [79:0] spreadShifted;
    logic [31:0] arrayOut;
    logic [31:0] mergedOut;

    // lsb of the operand lands at bit placeAmount of the 32-bit field
    assign placeAmount = {ctrlCode[7], ctrlCode}
        + (shiftOp.upperHalfRef ? UPPER_OFFSET : 9'h000);
    assign rightDist = FIELD_SPAN - placeAmount;
    // extension above, zeros below: one right shift covers both directions
    assign spread = {{32{extBit}}, operand, 32'h0000_0000};
    assign spreadShifted = spread >> rightDist[6:0];

    always_comb
    begin
        if ($signed(placeAmount) >= $signed(SAT_UP))
            arrayOut = 32'h0000_0000;
        else if ($signed(placeAmount) <= $signed(SAT_DOWN))
            arrayOut = {32{extBit}};
        else
            arrayOut = spreadShifted[31:0];
    end

    assign mergedOut = shiftOp.orMerge ? (arrayOut | curResult)
        : arrayOut;

    //////////////////////////////////////////////////////////////////////////
    // exponent detector and compare

    logic [4:0] upperCount;
    logic [4:0] lowerCount;
    logic overflowCase;
    logic [7:0] detExp;
    logic nextSign;
    logic isLower;
    logic blockGreater;

    assign isLower = (shiftOp.detMode == DET_LOWER);
    assign overflowCase = (shiftOp.detMode == DET_OVERFLOW_UPPER)
        && aluOverflowFlag;
    assign upperCount = leadCount(operand, operand[15]);
    assign lowerCount = leadCount(operand, shifterSignFlag);

    always_comb
    begin
        if (isLower)
            detExp = DET_LOWER_BASE - {3'b000, lowerCount};
        else if (overflowCase)
            detExp = DET_PLUS_ONE;
        else
            detExp = DET_PLUS_ONE - {3'b000, upperCount};
    end

    assign nextSign = overflowCase ? ~operand[15] : operand[15];
    // detector range is wider than 5 bits, so compare at 8 bits
    assign blockGreater = $signed(detExp)
        > $signed({{3{curBlock[4]}}, curBlock});

    //////////////////////////////////////////////////////////////////////////
    // operation write strobes

    logic opShiftWr;
    logic opExpWr;
    logic opBlockWr;
    logic opSignWr;

    assign opShiftWr = shiftOp.valid && (shiftOp.kind == OPK_SHIFT
        || shiftOp.kind == OPK_MANTISSA_ALIGN);
    assign opExpWr = shiftOp.valid
        && shiftOp.kind == OPK_LEADING_SIGN_COUNT
        && (!isLower || curExp == DET_LOWER_GATE);
    assign opSignWr = shiftOp.valid
        && shiftOp.kind == OPK_LEADING_SIGN_COUNT && !isLower;
    assign opBlockWr = shiftOp.valid
        && shiftOp.kind == OPK_BLOCK_EXP_ADJUST && blockGreater;

    //////////////////////////////////////////////////////////////////////////
    // bank select

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            activeBank <= RST_BANK;
        else if (bankEnable)
            activeBank <= 1'b1;
        else if (bankDisable)
            activeBank <= 1'b0;
        else if (modeStatusWrEn)
            activeBank <= modeStatusWrData[MODE_BANK_BIT];
    end

    //////////////////////////////////////////////////////////////////////////
    // register writes: memory bus write wins over an operation result
    // one block per register kind; only the visible bank slot is written

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int b = 0; b < BANKS; b++)
                shifterInput[b] <= RST_WORD;
        end
        else if (selHit(dmAccess.wrEn, dmAccess.sel, SEL_INPUT))
            shifterInput[bank] <= dmAccess.wrData;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int b = 0; b < BANKS; b++)
                shiftExponent[b] <= RST_SHIFT_EXP;
        end
        else if (selHit(dmAccess.wrEn, dmAccess.sel, SEL_SHIFT_EXP))
            shiftExponent[bank] <= dmAccess.wrData[7:0];
        else if (opExpWr)
            shiftExponent[bank] <= detExp;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int b = 0; b < BANKS; b++)
                blockExponent[b] <= RST_BLOCK_EXP;
        end
        else if (selHit(dmAccess.wrEn, dmAccess.sel, SEL_BLOCK_EXP))
            blockExponent[bank] <= dmAccess.wrData[4:0];
        else if (opBlockWr)
            blockExponent[bank] <= detExp[4:0];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int b = 0; b < BANKS; b++)
                resultLow[b] <= RST_WORD;
        end
        else if (selHit(dmAccess.wrEn, dmAccess.sel, SEL_RESULT_LOW))
            resultLow[bank] <= dmAccess.wrData;
        else if (opShiftWr)
            resultLow[bank] <= mergedOut[15:0];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int b = 0; b < BANKS; b++)
                resultHigh[b] <= RST_WORD;
        end
        else if (selHit(dmAccess.wrEn, dmAccess.sel, SEL_RESULT_HIGH))
            resultHigh[bank] <= dmAccess.wrData;
        else if (opShiftWr)
            resultHigh[bank] <= mergedOut[31:16];
    end

    //////////////////////////////////////////////////////////////////////////
    // shifter sign flag toward arithmetic status

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            shifterSignFlag <= 1'b0;
        else if (opSignWr)
            shifterSignFlag <= nextSign;
    end

    //////////////////////////////////////////////////////////////////////////
    // reads sample pre-edge contents, so same-cycle writes show next cycle

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            dmRdData <= RST_WORD;
        else if (dmAccess.rdEn)
        begin
            if (dmAccess.sel == SEL_INPUT)
                dmRdData <= curInput;
            else if (dmAccess.sel == SEL_SHIFT_EXP)
                dmRdData <= {{8{curExp[7]}}, curExp};
            else if (dmAccess.sel == SEL_BLOCK_EXP)
                dmRdData <= {{11{curBlock[4]}}, curBlock};
            else if (dmAccess.sel == SEL_RESULT_LOW)
                dmRdData <= curResult[15:0];
            else if (dmAccess.sel == SEL_RESULT_HIGH)
                dmRdData <= curResult[31:16];
            else
                dmRdData <= RST_WORD;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            resultBusOut <= RST_WORD;
        else if (resultBusRdEn)
            resultBusOut <= resultBusRdHigh ? curResult[31:16]
                : curResult[15:0];
    end

endmodule

// [testbench/core_seq_model.sv]
// partner model: core sequencer on memory bus, result bus and ops
`timescale 1ns/1ps
module core_seq_model
(
    input wire logic core_clk,
    input wire logic [15:0] dmRdData,
    input wire logic [15:0] resultBusOut,
    output dsp_shifter_pkg::dm_access_t dmAccess,
    output dsp_shifter_pkg::shift_op_t shiftOp,
    output logic resultBusRdEn,
    output logic resultBusRdHigh,
    output logic [15:0] resultBusIn
);
    import dsp_shifter_pkg::*;
    initial
    begin
        dmAccess = '0;
        shiftOp = '0;
        resultBusRdEn = 1'b0;
        resultBusRdHigh = 1'b0;
        resultBusIn = 16'h0000;
    end
    // one transfer per two cycles: no line changes twice in a step
    task acc(input logic w, r, input logic [2:0] s,
        input logic [15:0] d, output logic [15:0] q);
        @(negedge core_clk);
        dmAccess = {w, r, s, d};
        @(negedge core_clk);
        q = dmRdData;
        // released data inverted so a stale word never looks valid
        dmAccess = {2'b00, s, ~d};
    endtask
    task op(input shift_op_t o, input logic [15:0] b);
        @(negedge core_clk);
        shiftOp = o;
        resultBusIn = b;
        @(negedge core_clk);
        shiftOp = '0;
        resultBusIn = ~b;
    endtask
    task rbr(input logic h, output logic [15:0] q);
        @(negedge core_clk);
        resultBusRdEn = 1'b1;
        resultBusRdHigh = h;
        @(negedge core_clk);
        q = resultBusOut;
        resultBusRdEn = 1'b0;
    endtask
    // preset below any real exponent before a series of adjusts
    task bexp_init();
        logic [15:0] q;
        acc(1'b1, 1'b0, SEL_BLOCK_EXP, 16'hFFF0, q);
    endtask
endmodule

// [testbench/dsp_barrel_shifter_checker.sv]
// port assertions for the barrel shifter unit
`timescale 1ns/1ps
module dsp_barrel_shifter_checker
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire dsp_shifter_pkg::dm_access_t dmAccess,
    input wire logic [15:0] resultBusIn,
    input wire dsp_shifter_pkg::shift_op_t shiftOp,
    input wire logic aluOverflowFlag,
    input wire logic modeStatusWrEn,
    input wire logic [15:0] modeStatusWrData,
    input wire logic bankEnable,
    input wire logic bankDisable,
    input wire logic [15:0] dmRdData,
    input wire logic activeBank,
    input wire logic shifterSignFlag
);
    import dsp_shifter_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    wire upCount = shiftOp.valid && shiftOp.detMode != DET_LOWER
        && shiftOp.kind == OPK_LEADING_SIGN_COUNT;
    wire expSign = resultBusIn[15]
        ^ (aluOverflowFlag && shiftOp.detMode == DET_OVERFLOW_UPPER);
    wire rdExp = dmAccess.rdEn && dmAccess.sel == SEL_SHIFT_EXP;
    wire rdBexp = dmAccess.rdEn && dmAccess.sel == SEL_BLOCK_EXP;
    AST_RESET_BANK: assert property (!$past(arst_n) |-> !activeBank)
        else $error("bank not primary after reset");
    AST_BANK_ON: assert property (bankEnable |=> activeBank)
        else $error("enable did not pick alternate bank");
    AST_BANK_OFF: assert property
        (bankDisable && !bankEnable |=> !activeBank)
        else $error("disable did not pick primary bank");
    AST_MODE_BIT: assert property
        (modeStatusWrEn && !bankEnable && !bankDisable
        |=> activeBank == $past(modeStatusWrData[0]))
        else $error("mode bit 0 not followed");
    AST_EXP_SIGN: assert property
        (rdExp |=> dmRdData[15:8] == {8{dmRdData[7]}})
        else $error("shift exponent not sign extended");
    AST_BEXP_SIGN: assert property
        (rdBexp |=> dmRdData[15:5] == {11{dmRdData[4]}})
        else $error("block exponent not sign extended");
    AST_RD_STAND: assert property
        (!dmAccess.rdEn |=> $stable(dmRdData))
        else $error("read data moved without a read");
    AST_SIGN_LOAD: assert property
        (upCount && shiftOp.useResultBus |=> shifterSignFlag == $past(expSign))
        else $error("sign flag wrong after count");
    AST_SIGN_KEEP: assert property
        (!upCount |=> $stable(shifterSignFlag))
        else $error("sign flag moved without upper count");
    COV_BANK: cover property (bankEnable ##1 activeBank);
    COV_LOWER: cover property (shiftOp.valid && shiftOp.detMode == DET_LOWER);
    COV_MERGE: cover property (shiftOp.valid && shiftOp.orMerge);
endmodule
bind dsp_barrel_shifter dsp_barrel_shifter_checker checker_i (.*);

// [testbench/dsp_barrel_shifter_tb.sv]
// self-checking bench for the barrel shifter unit
`timescale 1ns/1ps
module dsp_barrel_shifter_tb;
    import dsp_shifter_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic aluCarryFlag = 1'b0;
    logic aluOverflowFlag = 1'b0;
    logic modeStatusWrEn = 1'b0;
    logic [15:0] modeStatusWrData = 16'h0000;
    logic bankEnable = 1'b0;
    logic bankDisable = 1'b0;
    logic resultBusRdEn, resultBusRdHigh, activeBank, shifterSignFlag;
    logic [15:0] resultBusIn, dmRdData, resultBusOut, q;
    dm_access_t dmAccess;
    shift_op_t shiftOp;
    int errors = 0;
    int n_compared = 0;
    // code, upper, ext source, bus operand, expected 32-bit result
    logic [51:0] shTab [11] = '{52'hF_B120_05B5_1800, 52'hF_B100_FDB5_1800,
        52'h0_5020_0016_D460, 52'h1_0100_0000_0000, 52'h0_F120_8000_0000,
        52'hE_0100_FFFF_FFFF, 52'hE_1120_0000_0001, 52'h2_0000_0000_0000,
        52'hF_0000_FFFF_FFFF, 52'hF_B111_F9B5_1800, 52'hF_B101_01B5_1800};
    // mode, operand, overflow, expected exponent, expected sign flag
    logic [43:0] dtTab [6] = '{44'h0F5_B10F_FFD1, 44'h1F5_B110_0010,
        44'h1F5_B10F_FFD1, 44'h200_000F_FFD1, 44'h0FF_FF0F_FF11,
        44'h2F5_B10F_FED1};
    always #4 core_clk = ~core_clk;
    dsp_barrel_shifter dut (.*);
    core_seq_model p (.*);
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic shift_op_t mk(logic [1:0] k, c, logic [7:0] i,
        logic u, logic [1:0] e, logic o, logic [1:0] d, logic r);
        return {1'b1, k, c, i, u, e, o, d, r};
    endfunction
    task rd(input logic [2:0] s, input logic [15:0] e);
        p.acc(1'b0, 1'b1, s, 16'h0000, q);
        chk($sformatf("register %0d", s), e, q);
    endtask
    task wr(input logic [2:0] s, input logic [15:0] d);
        p.acc(1'b1, 1'b0, s, d, q);
    endtask
    // high half over both buses, low half over the result bus
    task res(input logic [31:0] e);
        p.acc(1'b0, 1'b1, SEL_RESULT_HIGH, 16'h0000, q);
        chk("result high", e[31:16], q);
        p.rbr(1'b0, q);
        chk("result low", e[15:0], q);
        p.rbr(1'b1, q);
        chk("result bus high", e[31:16], q);
    endtask
    task bank(input logic e, d, w, b, x);
        @(negedge core_clk);
        bankEnable = e;
        bankDisable = d;
        modeStatusWrEn = w;
        modeStatusWrData = {15'h0, b};
        @(negedge core_clk);
        bankEnable = 1'b0;
        bankDisable = 1'b0;
        modeStatusWrEn = 1'b0;
        chk("bank", {15'h0, x}, {15'h0, activeBank});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset();
        chk("bank", 16'h0000, {15'h0, activeBank});
        rd(SEL_SHIFT_EXP, 16'h0000);
        rd(SEL_RESULT_HIGH, 16'h0000);
        rd(3'h5, 16'h0000);
    endtask
    task t_imm();
        wr(SEL_INPUT, 16'hB6A3);
        wr(SEL_SHIFT_EXP, 16'h0005);
        aluCarryFlag = 1'b1;
        foreach (shTab[j])
        begin
            p.op(mk(0, 2, shTab[j][51:44], shTab[j][40], shTab[j][37:36],
                0, 0, shTab[j][32]), 16'h36A3);
            res(shTab[j][31:0]);
        end
        rd(SEL_SHIFT_EXP, 16'h0005);
    endtask
    task t_exp();
        wr(SEL_SHIFT_EXP, 16'hAAFD);
        rd(SEL_SHIFT_EXP, 16'hFFFD);
        p.op(mk(0, 0, 0, 1, 0, 0, 0, 0), 16'h0000);
        res(32'hF6D4_6000);
        wr(SEL_INPUT, 16'h7676);
        p.op(mk(0, 0, 0, 0, 2, 1, 0, 0), 16'h0000);
        res(32'hF6D4_6ECE);
        p.op(mk(0, 1, 0, 1, 2, 0, 0, 0), 16'h0000);
        res(32'hB3B0_0000);
        p.op(mk(1, 2, 0, 0, 2, 0, 0, 0), 16'h0000);
        res(32'h0003_B3B0);
        wr(SEL_RESULT_LOW, 16'h1234);
        wr(SEL_RESULT_HIGH, 16'h8765);
        rd(SEL_RESULT_LOW, 16'h1234);
        res(32'h8765_1234);
    endtask
    task t_det();
        foreach (dtTab[j])
        begin
            aluOverflowFlag = dtTab[j][20];
            p.op(mk(2, 0, 0, 0, 0, 0, dtTab[j][41:40], 1), dtTab[j][39:24]);
            chk("sign flag", 16'(dtTab[j][0]), 16'(shifterSignFlag));
            rd(SEL_SHIFT_EXP, dtTab[j][19:4]);
        end
        p.bexp_init();
        rd(SEL_BLOCK_EXP, 16'hFFF0);
        p.op(mk(3, 0, 0, 0, 0, 0, 0, 1), 16'hF5B1);
        rd(SEL_BLOCK_EXP, 16'hFFFD);
        p.op(mk(3, 0, 0, 0, 0, 0, 0, 1), 16'h0176);
        rd(SEL_BLOCK_EXP, 16'hFFFD);
        p.op(mk(3, 0, 0, 0, 0, 0, 0, 1), 16'h4000);
        rd(SEL_BLOCK_EXP, 16'h0000);
    endtask
    task t_bank();
        bank(1, 0, 0, 0, 1);
        rd(SEL_INPUT, 16'h0000);
        rd(SEL_SHIFT_EXP, 16'h0000);
        wr(SEL_INPUT, 16'hABCD);
        bank(0, 0, 1, 0, 0);
        rd(SEL_INPUT, 16'h7676);
        p.acc(1'b1, 1'b1, SEL_INPUT, 16'h5555, q);
        chk("same cycle read", 16'h7676, q);
        rd(SEL_INPUT, 16'h5555);
        bank(0, 0, 1, 1, 1);
        rd(SEL_INPUT, 16'hABCD);
        bank(0, 1, 1, 1, 0);
        bank(1, 1, 1, 0, 1);
        @(negedge core_clk);
        arst_n = 1'b0;
        @(negedge core_clk);
        arst_n = 1'b1;
        chk("bank after reset", 16'h0000, 16'(activeBank));
        rd(SEL_INPUT, 16'h0000);
    endtask
    task results();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        t_reset();
        t_imm();
        t_exp();
        t_det();
        t_bank();
        results();
    end
    // watchdog: a hang counts as a mismatch
    initial
    begin
        #400000;
        errors++;
        results();
    end
endmodule
